// ==== pkg/sleep_power_defines.vh ====
`ifndef SLEEP_POWER_DEFINES_VH
`define SLEEP_POWER_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_SLEEP_MODE_CONTROL      8'h00
`define OFS_MICRO_CONTROL           8'h04
`define OFS_PERIPHERAL_CLOCK_GATING 8'h08
`define OFS_POWER_STATUS            8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_SLEEP_ARM               0
`define BIT_SLEEP_MODE_LO           1
`define BIT_SLEEP_MODE_HI           2
`define BIT_BROWNOUT_SLEEP_OFF      6
`define BIT_BROWNOUT_UNLOCK         5
`define BIT_GATE_TWO_WIRE           7
`define BIT_GATE_TIMER_ZERO         5
`define BIT_GATE_TIMER_ONE          3
`define BIT_GATE_SERIAL             2
`define BIT_GATE_CONVERTER          0

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define MASK_SLEEP_MODE_CONTROL     8'h07
`define MASK_PERIPHERAL_GATING      8'hAD
`define RST_SLEEP_MODE_CONTROL      8'h00
`define RST_PERIPHERAL_GATING       8'h00

// ----------------------------------------
// Sleep mode codes
// ----------------------------------------
`define MODE_IDLE                   2'b00
`define MODE_NOISE_REDUCTION        2'b01
`define MODE_POWER_DOWN             2'b10
`define MODE_RESERVED               2'b11

// ----------------------------------------
// Timing counts in clock cycles
// ----------------------------------------
`define UNLOCK_WINDOW_CYCLES        3'd4
`define BROWNOUT_OFF_CYCLES         3'd3
`define WAKE_HOLD_CYCLES            8'd4
`define STARTUP_CYCLES              8'd16
`define RESET_STARTUP_CYCLES        8'd64

`endif

// ==== design/brownout_unlock_seq.v ====
`timescale 1ns/1ps
`include "sleep_power_defines.vh"

module brownout_unlock_seq (
    input  wire core_clk,
    input  wire rst_sync_n,
    input  wire wr_micro,
    input  wire wr_sleep_off,
    input  wire wr_unlock,
    output reg  brownout_sleep_off,
    output wire brownout_sleep_off_unlock
);

    reg [2:0] window_cnt;
    reg [2:0] off_cnt;

    assign brownout_sleep_off_unlock = (window_cnt != 3'd0);

    // ----------------------------------------
    // Timed unlock window
    // ----------------------------------------
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            window_cnt <= 3'd0;
        end else if (wr_micro && wr_sleep_off && wr_unlock) begin
            window_cnt <= `UNLOCK_WINDOW_CYCLES;
        end else if (wr_micro) begin
            window_cnt <= 3'd0;
        end else if (window_cnt != 3'd0) begin
            window_cnt <= window_cnt - 3'd1;
        end
    end

    // ----------------------------------------
    // Sleep-off bit with self clear
    // ----------------------------------------
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            brownout_sleep_off <= 1'b0;
            off_cnt            <= 3'd0;
        end else if (wr_micro && wr_sleep_off && !wr_unlock
                     && brownout_sleep_off_unlock) begin
            brownout_sleep_off <= 1'b1;
            off_cnt            <= `BROWNOUT_OFF_CYCLES;
        end else if (off_cnt > 3'd1) begin
            off_cnt <= off_cnt - 3'd1;
        end else begin
            brownout_sleep_off <= 1'b0;
            off_cnt            <= 3'd0;
        end
    end

endmodule

// ==== design/sleep_power_reduction_control.v ====
// What this block does
// - Mode field picks idle, noise, power-down
// - Sleep instruction sleeps only when armed
// - Sleep control upper bits read zero
// - Sleep-off bit turns brown-out off asleep
// - Two writes within four cycles unlock
// - Sleep-off bit self clears after three
// - Unlock bit gates sleep-off bit writes
// - Micro control reserved bits read zero
// - Gating bit stops clock, blocks access
// - Clearing gate resumes peripheral unchanged
// - Gating acts in active and idle
// - Bit seven stops two-wire clock
// - Bits five, three stop timers
// - Bit two stops serial peripheral clock
// - Bit zero stops converter, comparator too
// - Gating bits six, four, one read zero
// - Input buffers off when io, adc stopped
// - Enabled watchdog keeps running asleep
// - Debug fuse keeps oscillator on asleep
// - Reference on only when someone needs it
// - Idle stops only cpu and flash
// - Wake holds cpu four extra cycles
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "sleep_power_defines.vh"

module sleep_power_reduction_control (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    input  wire        sleep_instr,
    input  wire        wake_event,
    input  wire        debug_enable_fuse,
    input  wire        watchdog_enabled,
    input  wire        brownout_fuse_enable,
    input  wire        adc_enable,
    input  wire        comparator_bandgap,
    output reg         cpu_clk_en,
    output reg         flash_clk_en,
    output reg         io_clk_en,
    output reg         adc_clk_en,
    output reg         main_osc_en,
    output reg         two_wire_clk_en,
    output reg         timer_zero_clk_en,
    output reg         timer_one_clk_en,
    output reg         serial_clk_en,
    output reg         converter_clk_en,
    output reg         two_wire_access_en,
    output reg         timer_zero_access_en,
    output reg         timer_one_access_en,
    output reg         serial_access_en,
    output reg         converter_access_en,
    output reg         comparator_usable,
    output reg         input_buffer_disable,
    output reg         brownout_detector_on,
    output reg         watchdog_run,
    output reg         vref_on,
    output reg         cpu_hold,
    output reg         wake_done
);

    // ----------------------------------------
    // State codes
    // ----------------------------------------
    localparam [2:0] ST_ACTIVE = 3'b001;
    localparam [2:0] ST_SLEEP  = 3'b010;
    localparam [2:0] ST_WAKE   = 3'b100;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function addr_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            addr_hit = (addr == ofs);
        end
    endfunction

    function mode_io_runs;
        input [1:0] mode;
        begin
            mode_io_runs = (mode == `MODE_IDLE);
        end
    endfunction

    function mode_adc_runs;
        input [1:0] mode;
        begin
            mode_adc_runs = (mode == `MODE_IDLE) || (mode == `MODE_NOISE_REDUCTION);
        end
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg rst_meta;
    reg rst_sync_n;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // Pin and fuse synchronisers
    // ----------------------------------------
    reg [3:0] pin_meta;
    reg [3:0] pin_sync;

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {brownout_fuse_enable, watchdog_enabled,
                         debug_enable_fuse, wake_event};
            pin_sync <= pin_meta;
        end
    end

    wire wake_sync     = pin_sync[0];
    wire debug_sync    = pin_sync[1];
    wire watchdog_sync = pin_sync[2];
    wire bod_fuse_sync = pin_sync[3];

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire access  = psel && penable;
    wire wr_en   = access && pwrite;
    wire hit_smc = addr_hit(paddr, `OFS_SLEEP_MODE_CONTROL);
    wire hit_mcu = addr_hit(paddr, `OFS_MICRO_CONTROL);
    wire hit_pcg = addr_hit(paddr, `OFS_PERIPHERAL_CLOCK_GATING);
    wire hit_sts = addr_hit(paddr, `OFS_POWER_STATUS);
    wire mapped  = hit_smc || hit_mcu || hit_pcg || hit_sts;

    assign pready = 1'b1;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    reg [2:0] sleep_mode_control;
    reg [7:0] peripheral_clock_gating;

    wire       sleep_arm         = sleep_mode_control[`BIT_SLEEP_ARM];
    wire [1:0] sleep_mode_select = sleep_mode_control[`BIT_SLEEP_MODE_HI:`BIT_SLEEP_MODE_LO];

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sleep_mode_control      <= 3'h0;
            peripheral_clock_gating <= `RST_PERIPHERAL_GATING;
        end else begin
            if (wr_en && hit_smc) begin
                sleep_mode_control <= pwdata[2:0];
            end
            if (wr_en && hit_pcg) begin
                peripheral_clock_gating <= pwdata[7:0] & `MASK_PERIPHERAL_GATING;
            end
        end
    end

    // ----------------------------------------
    // Brown-out sleep-off sequence
    // ----------------------------------------
    wire brownout_sleep_off;
    wire brownout_sleep_off_unlock;

    brownout_unlock_seq u_unlock (
        .core_clk                  (core_clk),
        .rst_sync_n                (rst_sync_n),
        .wr_micro                  (wr_en && hit_mcu),
        .wr_sleep_off              (pwdata[`BIT_BROWNOUT_SLEEP_OFF]),
        .wr_unlock                 (pwdata[`BIT_BROWNOUT_UNLOCK]),
        .brownout_sleep_off        (brownout_sleep_off),
        .brownout_sleep_off_unlock (brownout_sleep_off_unlock)
    );

    // ----------------------------------------
    // Sleep sequencer
    // ----------------------------------------
    reg [2:0] state;
    reg [2:0] next_state;
    reg [1:0] active_mode;
    reg       bod_off_period;
    reg [7:0] wake_cnt;

    wire sleep_go = sleep_instr && sleep_arm
                    && (sleep_mode_select != `MODE_RESERVED);

    always @* begin
        next_state = state;
        case (state)
            ST_ACTIVE: begin
                if (sleep_go) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_sync) begin
                    next_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wake_cnt == 8'd1) begin
                    next_state = ST_ACTIVE;
                end
            end
            default: begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state          <= ST_ACTIVE;
            active_mode    <= `MODE_IDLE;
            bod_off_period <= 1'b0;
            wake_cnt       <= 8'd0;
            wake_done      <= 1'b0;
        end else begin
            state     <= next_state;
            wake_done <= (state == ST_WAKE) && (next_state == ST_ACTIVE);
            if (state == ST_ACTIVE && sleep_go) begin
                active_mode    <= sleep_mode_select;
                bod_off_period <= brownout_sleep_off;
            end
            if (state == ST_SLEEP && wake_sync) begin
                if (bod_off_period) begin
                    wake_cnt <= `RESET_STARTUP_CYCLES + `WAKE_HOLD_CYCLES;
                end else begin
                    wake_cnt <= `STARTUP_CYCLES + `WAKE_HOLD_CYCLES;
                end
            end else if (state == ST_WAKE && wake_cnt != 8'd0) begin
                wake_cnt <= wake_cnt - 8'd1;
            end
            if (state == ST_WAKE && next_state == ST_ACTIVE) begin
                bod_off_period <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Clock and power outputs
    // ----------------------------------------
    wire asleep    = (state == ST_SLEEP);
    wire io_run    = !asleep || mode_io_runs(active_mode);
    wire adc_run   = !asleep || mode_adc_runs(active_mode);
    wire osc_run   = !asleep || (active_mode != `MODE_POWER_DOWN) || debug_sync;
    wire g_twi     = peripheral_clock_gating[`BIT_GATE_TWO_WIRE];
    wire g_tim0    = peripheral_clock_gating[`BIT_GATE_TIMER_ZERO];
    wire g_tim1    = peripheral_clock_gating[`BIT_GATE_TIMER_ONE];
    wire g_spi     = peripheral_clock_gating[`BIT_GATE_SERIAL];
    wire g_adc     = peripheral_clock_gating[`BIT_GATE_CONVERTER];
    wire bod_on    = bod_fuse_sync && !(asleep && bod_off_period);

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cpu_clk_en           <= 1'b1;
            flash_clk_en         <= 1'b1;
            io_clk_en            <= 1'b1;
            adc_clk_en           <= 1'b1;
            main_osc_en          <= 1'b1;
            two_wire_clk_en      <= 1'b1;
            timer_zero_clk_en    <= 1'b1;
            timer_one_clk_en     <= 1'b1;
            serial_clk_en        <= 1'b1;
            converter_clk_en     <= 1'b1;
            two_wire_access_en   <= 1'b1;
            timer_zero_access_en <= 1'b1;
            timer_one_access_en  <= 1'b1;
            serial_access_en     <= 1'b1;
            converter_access_en  <= 1'b1;
            comparator_usable    <= 1'b1;
            input_buffer_disable <= 1'b0;
            brownout_detector_on <= 1'b0;
            watchdog_run         <= 1'b0;
            vref_on              <= 1'b0;
            cpu_hold             <= 1'b0;
        end else begin
            cpu_clk_en           <= !asleep;
            flash_clk_en         <= !asleep;
            io_clk_en            <= io_run;
            adc_clk_en           <= adc_run;
            main_osc_en          <= osc_run;
            two_wire_clk_en      <= io_run && !g_twi;
            timer_zero_clk_en    <= io_run && !g_tim0;
            timer_one_clk_en     <= io_run && !g_tim1;
            serial_clk_en        <= io_run && !g_spi;
            converter_clk_en     <= adc_run && !g_adc;
            two_wire_access_en   <= !g_twi;
            timer_zero_access_en <= !g_tim0;
            timer_one_access_en  <= !g_tim1;
            serial_access_en     <= !g_spi;
            converter_access_en  <= !g_adc;
            comparator_usable    <= !g_adc;
            input_buffer_disable <= !io_run && !adc_run;
            brownout_detector_on <= bod_on;
            watchdog_run         <= watchdog_sync;
            vref_on              <= bod_on || comparator_bandgap || adc_enable;
            cpu_hold             <= (next_state != ST_ACTIVE);
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= !mapped;
                if (hit_smc) begin
                    prdata <= {29'h0, sleep_mode_control};
                end else if (hit_mcu) begin
                    prdata <= {24'h0, 1'b0, brownout_sleep_off,
                               brownout_sleep_off_unlock, 5'h00};
                end else if (hit_pcg) begin
                    prdata <= {24'h0, peripheral_clock_gating};
                end else if (hit_sts) begin
                    prdata <= {24'h0, bod_off_period, active_mode, 2'b00, state};
                end
            end else if (access) begin
                prdata  <= prdata;
                pslverr <= pslverr;
            end
        end
    end

endmodule

// ==== tb/sleep_power_properties.sv ====
`timescale 1ns/1ps
module sleep_power_properties (
    input wire        core_clk,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        sleep_instr,
    input wire        watchdog_enabled,
    input wire        adc_enable,
    input wire        comparator_bandgap,
    input wire        cpu_clk_en,
    input wire        flash_clk_en,
    input wire        io_clk_en,
    input wire        adc_clk_en,
    input wire        input_buffer_disable,
    input wire        timer_zero_clk_en,
    input wire        timer_one_clk_en,
    input wire        converter_access_en,
    input wire        comparator_usable,
    input wire        watchdog_run,
    input wire        vref_on,
    input wire        cpu_hold,
    input wire        wake_done
);
    // ----------------------------------------
    // Shadow of written control state
    // ----------------------------------------
    reg  [7:0] smc;
    reg  [7:0] gate;
    reg  [1:0] slp_mode;
    reg  [6:0] hold_cnt;
    wire       acc = psel && penable;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            smc      <= 8'h00;
            gate     <= 8'h00;
            slp_mode <= 2'b00;
            hold_cnt <= 7'h00;
        end else begin
            if (acc && pwrite && paddr == 8'h00)
                smc <= pwdata[7:0];
            if (acc && pwrite && paddr == 8'h08)
                gate <= pwdata[7:0];
            if (sleep_instr && !cpu_hold)
                slp_mode <= smc[2:1];
            if (!cpu_hold)
                hold_cnt <= 7'h00;
            else if (hold_cnt != 7'h7F)
                hold_cnt <= hold_cnt + 7'h01;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_ENTER: assert property (
        sleep_instr && !cpu_hold && smc[0] && smc[2:1] != 2'b11 |=> cpu_hold)
        else $error("armed sleep not entered");
    AST_REFUSE: assert property (
        sleep_instr && !cpu_hold && (!smc[0] || smc[2:1] == 2'b11) |=> !cpu_hold)
        else $error("unarmed sleep entered");
    AST_CPU_OFF: assert property (
        $rose(cpu_hold) |=> !cpu_clk_en && !flash_clk_en)
        else $error("cpu clocks still on in sleep");
    AST_MODE_CLOCKS: assert property (
        $fell(cpu_clk_en) |-> io_clk_en == (slp_mode == 2'b00)
            && adc_clk_en == (slp_mode != 2'b10)
            && input_buffer_disable == (slp_mode == 2'b10))
        else $error("sleep clock set wrong for mode");
    AST_ACCESS: assert property (
        converter_access_en == !$past(gate[0]) && comparator_usable == !$past(gate[0]))
        else $error("converter access not following gate");
    AST_TIMER_GATE: assert property (
        cpu_clk_en |-> timer_zero_clk_en == !$past(gate[5])
            && timer_one_clk_en == !$past(gate[3]))
        else $error("timer clock not following gate");
    AST_WAKE_HOLD: assert property (
        $fell(cpu_hold) |-> wake_done && hold_cnt >= 7'd20)
        else $error("wake hold too short");
    AST_WAKE_PULSE: assert property (
        wake_done |=> !wake_done)
        else $error("wake done longer than one cycle");
    AST_VREF: assert property (
        $past(comparator_bandgap || adc_enable) |-> vref_on)
        else $error("reference off while needed");
    AST_WDOG: assert property (
        watchdog_enabled [*8] |-> watchdog_run)
        else $error("watchdog stopped");
    AST_SMC_RSVD: assert property (
        acc && !pwrite && paddr == 8'h00 |-> prdata[31:3] == 29'h0)
        else $error("sleep control reserved bits set");
    AST_MCU_RSVD: assert property (
        acc && !pwrite && paddr == 8'h04 |-> (prdata & 32'hFFFFFF9F) == 32'h0)
        else $error("micro control reserved bits set");
    AST_GATE_RSVD: assert property (
        acc && !pwrite && paddr == 8'h08 |-> (prdata & 32'hFFFFFF52) == 32'h0)
        else $error("gating reserved bits set");
endmodule

// ==== tb/core_partner.sv ====
`timescale 1ns/1ps
module core_partner (
    input  wire core_clk,
    input  wire wake_done,
    output reg  sleep_instr = 1'b0,
    output reg  wake_event  = 1'b0
);
    // One-cycle sleep instruction
    task automatic exec_sleep;
        sleep_instr <= 1'b1;
        @(posedge core_clk);
        sleep_instr <= 1'b0;
    endtask

    // Wake level held until core resumes
    task automatic wake(output int cycles);
        cycles = 0;
        @(posedge core_clk);
        wake_event <= 1'b1;
        while (cycles < 500) begin
            @(negedge core_clk);
            cycles++;
            if (wake_done === 1'b1)
                break;
        end
        @(posedge core_clk);
        wake_event <= 1'b0;
    endtask
endmodule

// ==== tb/sleep_power_reduction_control_tb_top.sv ====
`timescale 1ns/1ps
module sleep_power_reduction_control_tb_top;
    logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sleep_instr, wake_event, debug_enable_fuse, watchdog_enabled;
    logic        brownout_fuse_enable, adc_enable, comparator_bandgap;
    logic        cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en, main_osc_en;
    logic        two_wire_clk_en, timer_zero_clk_en, timer_one_clk_en, serial_clk_en;
    logic        converter_clk_en, two_wire_access_en, timer_zero_access_en;
    logic        timer_one_access_en, serial_access_en, converter_access_en;
    logic        comparator_usable, input_buffer_disable, brownout_detector_on;
    logic        watchdog_run, vref_on, cpu_hold, wake_done;
    int          n_errors, n_checks, cyc;
    int          gbit [5] = '{7, 5, 3, 2, 0};
    logic [31:0] smc_v [2] = '{32'h000000FF, 32'h000000FC};
    wire  [4:0]  clkv = {two_wire_clk_en, timer_zero_clk_en, timer_one_clk_en,
                         serial_clk_en, converter_clk_en};
    wire  [4:0]  accv = {two_wire_access_en, timer_zero_access_en, timer_one_access_en,
                         serial_access_en, converter_access_en};

    sleep_power_reduction_control sleep_power_reduction_control_i (.*);
    core_partner core_partner_i (.*);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        begin
            n_checks++;
            if (got !== exp) begin
                n_errors++;
                $display("[ERR] %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
        begin
            n_checks++;
            if (got < lo || got > hi) begin
                n_errors++;
                $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
            end
        end
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk(nm, exp, rd);
        end
    endtask

    task automatic sleep_case(input logic [1:0] m, input logic dbg, input logic off);
        begin
            debug_enable_fuse <= dbg;
            apb(1'b1, 8'h00, {29'h0, m, 1'b1});
            if (off) begin
                apb(1'b1, 8'h04, 32'h60);
                apb(1'b1, 8'h04, 32'h40);
            end
            core_partner_i.exec_sleep();
            repeat (4) @(posedge core_clk);
            @(negedge core_clk);
            chk("cpu_clk_en", 0, cpu_clk_en);
            chk("io_clk_en", m == 2'b00, io_clk_en);
            chk("adc_clk_en", m != 2'b10, adc_clk_en);
            chk("main_osc_en", m != 2'b10 || dbg, main_osc_en);
            chk("input_buffer_disable", m == 2'b10, input_buffer_disable);
            chk("gated clocks", {m == 2'b00, 1'b0, {2{m == 2'b00}}, m != 2'b10}, clkv);
            chk("watchdog_run", 1, watchdog_run);
            chk("brownout_detector_on", !off, brownout_detector_on);
            chk("vref_on", !off, vref_on);
            core_partner_i.wake(cyc);
            chk_rng("wake cycles", off ? 68 : 20, off ? 76 : 28, cyc);
            apb(1'b1, 8'h00, 32'h0);
        end
    endtask

    task automatic end_sim;
        begin
            if (n_errors == 0 && n_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, debug_enable_fuse, adc_enable,
         comparator_bandgap} = '0;
        {watchdog_enabled, brownout_fuse_enable} = 2'b11;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        rdchk("sleep_mode_control", 8'h00, 32'h0);
        rdchk("micro_control", 8'h04, 32'h0);
        rdchk("peripheral_clock_gating", 8'h08, 32'h0);
        foreach (smc_v[i]) begin
            apb(1'b1, 8'h00, smc_v[i]);
            rdchk("sleep_mode_control", 8'h00, smc_v[i] & 32'h7);
            core_partner_i.exec_sleep();
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            chk("cpu_hold", 0, cpu_hold);
            @(posedge core_clk);
        end
        apb(1'b1, 8'h04, 32'h9F);
        rdchk("micro_control", 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'hFF);
        rdchk("peripheral_clock_gating", 8'h08, 32'hAD);
        rdchk("unmapped", 8'h10, 32'h0);
        chk("pslverr", 1, er);
        foreach (gbit[i]) begin
            apb(1'b1, 8'h08, 32'h1 << gbit[i]);
            @(negedge core_clk);
            chk("gated clocks", ~(5'h10 >> i) & 5'h1F, clkv);
            chk("gated access", ~(5'h10 >> i) & 5'h1F, accv);
            chk("comparator_usable", i != 4, comparator_usable);
            @(posedge core_clk);
        end
        apb(1'b1, 8'h08, 32'h20);
        @(negedge core_clk);
        chk("gated clocks", 5'h17, clkv);
        @(posedge core_clk);
        apb(1'b1, 8'h04, 32'h40);
        rdchk("micro_control", 8'h04, 32'h0);
        apb(1'b1, 8'h04, 32'h60);
        repeat (5) @(posedge core_clk);
        apb(1'b1, 8'h04, 32'h40);
        rdchk("micro_control", 8'h04, 32'h0);
        apb(1'b1, 8'h04, 32'h60);
        apb(1'b1, 8'h04, 32'h40);
        rdchk("micro_control", 8'h04, 32'h40);
        repeat (4) @(posedge core_clk);
        rdchk("micro_control", 8'h04, 32'h0);
        brownout_fuse_enable <= 1'b0;
        watchdog_enabled     <= 1'b0;
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < 3; i++) begin
            comparator_bandgap <= (i == 1);
            adc_enable         <= (i == 2);
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            chk("vref_on", i != 0, vref_on);
            chk("watchdog_run", 0, watchdog_run);
            @(posedge core_clk);
        end
        adc_enable           <= 1'b0;
        brownout_fuse_enable <= 1'b1;
        watchdog_enabled     <= 1'b1;
        repeat (8) @(posedge core_clk);
        sleep_case(2'b00, 1'b0, 1'b0);
        sleep_case(2'b01, 1'b0, 1'b0);
        sleep_case(2'b10, 1'b0, 1'b0);
        sleep_case(2'b10, 1'b1, 1'b0);
        sleep_case(2'b10, 1'b0, 1'b1);
        end_sim();
    end

    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
endmodule

bind sleep_power_reduction_control sleep_power_properties sleep_power_properties_i (.*);
